/* File: core/asch_sched.sv */
// Auto-send scheduler of a gauge radio module: command intake, rate limit,
// keep-alive and inactivity exit. Assumes synchronous inputs on one clock.
`timescale 1ns/100ps
module asch_sched
   import asch_pkg::*;
#(
   parameter int MS_CYCLES = TICK_CYCLES,
   parameter bit FIXED_RATE = 1'b0,
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic key_press,
   input wire logic cmd_valid,
   input wire asch_cmd_t cmd,
   input wire logic button_short,
   input wire logic button_long,
   input wire logic meas_valid,
   input wire logic [VAL_W-1:0] meas_value,
   output logic tx_valid,
   input wire logic tx_ready,
   output asch_tx_t tx_data,
   output logic [ADDR_W-1:0] sender_addr,
   output asch_rate_t radio_rate,
   output logic auto_mode,
   output logic cmd_reject,
   output logic green_led,
   output logic tone_on
);
   localparam int PW = $clog2(MS_CYCLES + 1);
   localparam logic [11:0] FIXED_PERIOD_MS = 12'(MS_PER_S / FIXED_RATE_HZ);
   localparam logic [11:0] SLOT_SAT = 12'hfff;
   localparam logic [13:0] IDLE_SAT = 14'h3fff;
   if (MS_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_bad_param
      $error("asch_sched: MS_CYCLES must be positive and FIFO_DEPTH at least 2");
   end
   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   logic [PW-1:0] pre_q, pre_d;
   logic [9:0] ms_q, ms_d;
   logic ms_tick, s_tick;
   // Millisecond and second ticks shared by every timer below.
   always_comb begin
      ms_tick = pre_q == PW'(MS_CYCLES - 1);
      pre_d = ms_tick ? '0 : pre_q + 1'b1;
      s_tick = ms_tick && (ms_q == 10'(MS_PER_S - 1));
      ms_d = ms_tick ? (s_tick ? '0 : ms_q + 1'b1) : ms_q;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pre_q <= '0;
         ms_q <= '0;
      end else begin
         pre_q <= pre_d;
         ms_q <= ms_d;
      end
   end
   // ---------------------------------------------------------------
   // Command intake and configuration
   // ---------------------------------------------------------------
   logic armed_q, armed_d, rej_q, rej_d, cmd_take, cmd_ok;
   logic [ADDR_W-1:0] addr_q, addr_d;
   asch_rate_t rate_q, rate_d;
   logic [3:0] maxr_q, maxr_d;
   asch_btn_t btn_q, btn_d;
   logic [7:0] tmo_q, tmo_d, ka_q, ka_d;
   // A queued command only lands in the window opened by a data-key press;
   // a key press in the same cycle as a delivery keeps the window open.
   always_comb begin
      cmd_take = cmd_valid && armed_q;
      cmd_ok = 1'b0;
      armed_d = key_press ? 1'b1 : (cmd_take ? 1'b0 : armed_q);
      addr_d = addr_q;
      rate_d = rate_q;
      maxr_d = maxr_q;
      btn_d = btn_q;
      tmo_d = tmo_q;
      ka_d = ka_q;
      rej_d = 1'b0;
      if (cmd_take) begin
         case (cmd.op)
            ASCH_OP_ADDR: begin
               if (cmd.arg[15:ADDR_W] == '0 && cmd.arg[ADDR_W-1:0] >= ADDR_MIN &&
                   cmd.arg[ADDR_W-1:0] <= ADDR_MAX) begin
                  addr_d = cmd.arg[ADDR_W-1:0];
                  cmd_ok = 1'b1;
               end
            end
            ASCH_OP_RATE: begin
               if (addr_q == ADDR_RATE_KEY) begin
                  rate_d = asch_rate_t'(cmd.arg[0]);
                  cmd_ok = 1'b1;
               end
            end
            ASCH_OP_MAXR: begin
               if (cmd.arg[3:0] >= MAXR_MIN && cmd.arg[3:0] <= MAXR_MAX &&
                   cmd.arg[15:4] == '0) begin
                  maxr_d = cmd.arg[3:0];
                  cmd_ok = 1'b1;
               end
            end
            ASCH_OP_BTN: begin
               if (cmd.arg[1:0] != 2'h3) begin
                  btn_d = asch_btn_t'(cmd.arg[1:0]);
                  cmd_ok = 1'b1;
               end
            end
            ASCH_OP_TMO: begin
               tmo_d = cmd.arg[7:0];
               cmd_ok = 1'b1;
            end
            ASCH_OP_KA: begin
               ka_d = cmd.arg[7:0];
               cmd_ok = 1'b1;
            end
            default: cmd_ok = 1'b0;
         endcase
         rej_d = !cmd_ok;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         armed_q <= 1'b0;
         addr_q <= ADDR_RST;
         rate_q <= ASCH_RATE_LOW;
         maxr_q <= MAXR_RST;
         btn_q <= ASCH_BTN_OFF;
         tmo_q <= TMO_RST;
         ka_q <= KA_RST;
         rej_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
         addr_q <= addr_d;
         rate_q <= rate_d;
         maxr_q <= maxr_d;
         btn_q <= btn_d;
         tmo_q <= tmo_d;
         ka_q <= ka_d;
         rej_q <= rej_d;
      end
   end
   // ---------------------------------------------------------------
   // Acknowledge sequencer
   // ---------------------------------------------------------------
   asch_ack_t ack_q, ack_d;
   logic [2:0] ph_q, ph_d;
   logic [6:0] pms_q, pms_d;
   logic led_q, led_d;
   always_comb begin
      ack_d = ack_q;
      ph_d = ph_q;
      pms_d = pms_q;
      case (ack_q)
         ASCH_ACK_IDLE: begin
            if (cmd_ok) begin
               ack_d = ASCH_ACK_RUN;
               ph_d = '0;
               pms_d = '0;
            end
         end
         ASCH_ACK_RUN: begin
            if (ms_tick) begin
               pms_d = pms_q + 1'b1;
               if (pms_q == 7'(ACK_PHASE_MS - 1)) begin
                  pms_d = '0;
                  ph_d = ph_q + 1'b1;
                  if (ph_q == 3'(2 * ACK_FLASHES - 1)) begin
                     ack_d = ASCH_ACK_IDLE;
                  end
               end
            end
         end
         default: ack_d = ASCH_ACK_IDLE;
      endcase
      led_d = (ack_d == ASCH_ACK_RUN) && !ph_d[0];
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= ASCH_ACK_IDLE;
         ph_q <= '0;
         pms_q <= '0;
         led_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         ph_q <= ph_d;
         pms_q <= pms_d;
         led_q <= led_d;
      end
   end
   // ---------------------------------------------------------------
   // Scheduler
   // ---------------------------------------------------------------
   logic auto_q, auto_d, pend_q, pend_d;
   logic [VAL_W-1:0] last_q, last_d;
   logic [11:0] slot_q, slot_d, period;
   logic [7:0] kas_q, kas_d;
   logic [13:0] idle_q, idle_d;
   logic changed, toggle, slot_ok, ka_due, tmo_due, send, fifo_ready;
   asch_tx_t push_word;
   // Slot, keep-alive and idle timers saturate so a long quiet spell is safe.
   always_comb begin
      changed = meas_valid && (meas_value != last_q);
      last_d = meas_valid ? meas_value : last_q;
      period = FIXED_RATE ? FIXED_PERIOD_MS : asch_period_ms(maxr_q);
      slot_ok = slot_q >= period;
      ka_due = (ka_q != '0) && (kas_q >= ka_q);
      tmo_due = (tmo_q != '0) && (idle_q >= 14'(tmo_q) * 14'(S_PER_MIN));
      toggle = (btn_q == ASCH_BTN_SHORT && button_short) ||
               (btn_q == ASCH_BTN_LONG && button_long);
      pend_d = pend_q || (auto_q && changed);
      send = auto_q && fifo_ready && slot_ok && (pend_q || ka_due) && !tmo_due;
      if (send && !(auto_q && changed)) begin
         pend_d = 1'b0;
      end
      auto_d = auto_q;
      if (toggle) begin
         auto_d = !auto_q;
      end else if (tmo_due) begin
         auto_d = 1'b0;
      end
      if (rate_q != ASCH_RATE_HIGH) begin
         auto_d = 1'b0;
      end
      if (!auto_d) begin
         pend_d = 1'b0;
      end
      slot_d = send ? '0 : ((ms_tick && slot_q != SLOT_SAT) ? slot_q + 1'b1 : slot_q);
      kas_d = send ? '0 : ((s_tick && kas_q != 8'hff) ? kas_q + 1'b1 : kas_q);
      idle_d = (changed || (auto_d && !auto_q)) ? '0 :
               ((s_tick && idle_q != IDLE_SAT) ? idle_q + 1'b1 : idle_q);
      push_word.addr = addr_q;
      push_word.keepalive = !pend_q;
      push_word.value = last_q;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         auto_q <= 1'b0;
         pend_q <= 1'b0;
         last_q <= '0;
         slot_q <= SLOT_SAT;
         kas_q <= '0;
         idle_q <= '0;
      end else begin
         auto_q <= auto_d;
         pend_q <= pend_d;
         last_q <= last_d;
         slot_q <= slot_d;
         kas_q <= kas_d;
         idle_q <= idle_d;
      end
   end
   // Back-pressure from the radio side fills the FIFO; a send is held back only once it is full.
   asch_fifo #(.WIDTH(TX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(send),
      .in_ready(fifo_ready),
      .in_data(push_word),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );
   assign sender_addr = addr_q;
   assign radio_rate = rate_q;
   assign auto_mode = auto_q;
   assign cmd_reject = rej_q;
   assign green_led = led_q;
   assign tone_on = led_q;
endmodule

/* File: core/asch_pkg.sv */
// Shared constants, enumerations and carriers of the auto-send scheduler.
// Assumes a single 10 MHz clock and that all users import the whole package.
package asch_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_MS = 1;
   localparam int MS_PER_S = 1000;
   localparam int S_PER_MIN = 60;
   localparam int TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
   localparam int ACK_PHASE_MS = 100;
   localparam int ACK_FLASHES = 3;
   localparam int FIXED_RATE_HZ = 10;
   localparam int MAXR_SCALE_MS = 2000;

   // ---------------------------------------------------------------
   // Address and configuration values
   // ---------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam int VAL_W = 16;
   localparam logic [ADDR_W-1:0] ADDR_MIN = 9'h001;
   localparam logic [ADDR_W-1:0] ADDR_MAX = 9'h1f4;
   localparam logic [ADDR_W-1:0] ADDR_RATE_KEY = 9'h1f4;
   localparam logic [ADDR_W-1:0] ADDR_RST = 9'h001;
   localparam int BAUD_LOW = 9600;
   localparam int BAUD_HIGH = 230400;
   localparam logic [3:0] MAXR_MIN = 4'h1;
   localparam logic [3:0] MAXR_MAX = 4'ha;
   localparam logic [3:0] MAXR_RST = 4'h4;
   localparam logic [7:0] TMO_RST = 8'h00;
   localparam logic [7:0] KA_RST = 8'h00;

   typedef enum logic {
      ASCH_RATE_LOW = 1'b0,
      ASCH_RATE_HIGH = 1'b1
   } asch_rate_t;

   typedef enum logic [1:0] {
      ASCH_BTN_OFF = 2'b00,
      ASCH_BTN_SHORT = 2'b01,
      ASCH_BTN_LONG = 2'b10
   } asch_btn_t;

   typedef enum logic [2:0] {
      ASCH_OP_ADDR = 3'b000,
      ASCH_OP_RATE = 3'b001,
      ASCH_OP_MAXR = 3'b010,
      ASCH_OP_BTN = 3'b011,
      ASCH_OP_TMO = 3'b100,
      ASCH_OP_KA = 3'b101
   } asch_op_t;

   typedef enum logic {
      ASCH_ACK_IDLE = 1'b0,
      ASCH_ACK_RUN = 1'b1
   } asch_ack_t;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      asch_op_t op;
      logic [15:0] arg;
   } asch_cmd_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic keepalive;
      logic [VAL_W-1:0] value;
   } asch_tx_t;

   localparam int TX_W = $bits(asch_tx_t);

   // Least spacing in ms for a rate code in half-hertz steps.
   function automatic logic [11:0] asch_period_ms(input logic [3:0] code);
      logic [11:0] p;
      p = 12'(MAXR_SCALE_MS / 4);
      case (code)
         4'h1: p = 12'(MAXR_SCALE_MS / 1);
         4'h2: p = 12'(MAXR_SCALE_MS / 2);
         4'h3: p = 12'((MAXR_SCALE_MS + 2) / 3);
         4'h4: p = 12'(MAXR_SCALE_MS / 4);
         4'h5: p = 12'(MAXR_SCALE_MS / 5);
         4'h6: p = 12'((MAXR_SCALE_MS + 5) / 6);
         4'h7: p = 12'((MAXR_SCALE_MS + 6) / 7);
         4'h8: p = 12'(MAXR_SCALE_MS / 8);
         4'h9: p = 12'((MAXR_SCALE_MS + 8) / 9);
         4'ha: p = 12'(MAXR_SCALE_MS / 10);
         default: p = 12'(MAXR_SCALE_MS / 4);
      endcase
      return p;
   endfunction

endpackage

/* File: core/asch_fifo.sv */
// Small FIFO for outgoing values, with a registered head word.
// Assumes one clock; the drain side may hold ready low to stall.
`timescale 1ns/100ps
module asch_fifo
   import asch_pkg::*;
#(
   parameter int WIDTH = TX_W,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("asch_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic ov_q, ov_d;
   logic [WIDTH-1:0] od_q, od_d;
   logic push, pop;

   // The head register refills from storage whenever it is empty or taken.
   always_comb begin
      push = in_valid && in_ready;
      pop = (cnt_q != '0) && (!ov_q || out_ready);
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      ov_d = ov_q && !out_ready;
      od_d = od_q;
      if (pop) begin
         ov_d = 1'b1;
         od_d = mem[rd_q];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ov_q <= 1'b0;
         od_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         ov_q <= ov_d;
         od_q <= od_d;
      end
   end

   // Storage needs no reset; only words behind the count are ever read.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   assign in_ready = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = ov_q;
   assign out_data = od_q;
endmodule

/* File: dv/asch_sched_sva.sv */
// Port checks of the auto-send scheduler.
// Assumes it is bound onto asch_sched and sees only its ports.
`timescale 1ns/100ps
module asch_sched_chk
   import asch_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic key_press,
   input wire logic cmd_valid,
   input wire asch_cmd_t cmd,
   input wire logic button_short,
   input wire logic button_long,
   input wire logic meas_valid,
   input wire logic [VAL_W-1:0] meas_value,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire asch_tx_t tx_data,
   input wire logic [ADDR_W-1:0] sender_addr,
   input wire asch_rate_t radio_rate,
   input wire logic auto_mode,
   input wire logic cmd_reject,
   input wire logic green_led,
   input wire logic tone_on
);
   // ------------
   // Properties
   // ------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_reject_pulse: assert property (cmd_reject |=> !cmd_reject)
      else $error("reject pulse longer than one cycle");
   a_reject_cause: assert property (cmd_reject |-> $past(cmd_valid))
      else $error("reject without a command");
   a_addr_range: assert property (sender_addr >= ADDR_MIN && sender_addr <= ADDR_MAX)
      else $error("sender address out of range");
   // The rate may only move by a command taken while the key address is set.
   a_rate_key: assert property ($changed(radio_rate) |->
      $past(cmd_valid) && $past(sender_addr) == ADDR_RATE_KEY)
      else $error("rate changed away from key address");
   a_auto_rate: assert property ($rose(auto_mode) |-> radio_rate == ASCH_RATE_HIGH)
      else $error("auto mode entered at low rate");
   a_auto_button: assert property ($rose(auto_mode) |->
      $past(button_short || button_long))
      else $error("auto mode entered without a press");
   a_led_tone: assert property (green_led == tone_on)
      else $error("tone and indicator differ");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("send word dropped or changed");
   a_send_auto: assert property ($rose(tx_valid) |-> $past(auto_mode, 2))
      else $error("word sent outside auto mode");
endmodule

bind asch_sched asch_sched_chk u_chk (.clk(clk), .resetn(resetn), .key_press(key_press),
   .cmd_valid(cmd_valid), .cmd(cmd), .button_short(button_short),
   .button_long(button_long), .meas_valid(meas_valid), .meas_value(meas_value),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
   .sender_addr(sender_addr), .radio_rate(radio_rate), .auto_mode(auto_mode),
   .cmd_reject(cmd_reject), .green_led(green_led), .tone_on(tone_on));

/* File: dv/asch_rx_model.sv */
// Radio receiver model that takes words from the scheduler's send port.
// Assumes the bench moves stall just after a rising clock edge.
`timescale 1ns/100ps
module asch_rx_model
   import asch_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic stall,
   input wire asch_rate_t radio_rate,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire asch_tx_t tx_data,
   output int n_rx,
   output asch_tx_t last_q
);
   // ------------
   // Handshake
   // ------------
   // shared rate match
   // A receiver on the other rate hears nothing, so it never takes a word.
   assign tx_ready = resetn && !stall && radio_rate == ASCH_RATE_HIGH;

   // Count every word taken and keep the latest one for the bench.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         n_rx <= 0;
         last_q <= '0;
      end else if (tx_valid && tx_ready) begin
         n_rx <= n_rx + 1;
         last_q <= tx_data;
      end
   end
endmodule

/* File: dv/test_asch_sched.sv */
// Self-checking bench of the auto-send scheduler.
// Assumes the receiver model and the bound checker beside the design.
`timescale 1ns/100ps
module test_asch_sched
   import asch_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic key_press = 1'b0;
   logic cmd_valid = 1'b0;
   logic button_short = 1'b0;
   logic button_long = 1'b0;
   logic meas_valid = 1'b0;
   logic stall = 1'b0;
   logic rej, p;
   asch_cmd_t cmd = '0;
   logic [VAL_W-1:0] meas_value = '0;
   logic tx_valid, tx_ready, auto_mode, cmd_reject, green_led, tone_on;
   asch_tx_t tx_data, last_q;
   logic [ADDR_W-1:0] sender_addr;
   asch_rate_t radio_rate;
   logic tx_valid_f, tx_ready_f;
   asch_tx_t tx_data_f, last_f;
   asch_rate_t rate_f;
   int n_rx_f, base_f;
   int n_rx, base, k;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   // Refused commands: bad address, rate off key, bad rate code, bad button, bad op.
   asch_cmd_t bad [7] = '{'{ASCH_OP_ADDR, 16'h0000}, '{ASCH_OP_ADDR, 16'h01f5},
      '{ASCH_OP_RATE, 16'h0001}, '{ASCH_OP_MAXR, 16'h0000}, '{ASCH_OP_MAXR, 16'h000b},
      '{ASCH_OP_BTN, 16'h0003}, '{asch_op_t'(3'h6), 16'h0000}};

   // ------------
   // Clock and instances
   // ------------
   // One millisecond is one clock here, so the minute timeout fits the run.
   always #50 clk = ~clk;

   asch_sched #(.MS_CYCLES(1)) dut (.clk(clk), .resetn(resetn), .key_press(key_press),
      .cmd_valid(cmd_valid), .cmd(cmd), .button_short(button_short),
      .button_long(button_long), .meas_valid(meas_valid), .meas_value(meas_value),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .sender_addr(sender_addr), .radio_rate(radio_rate), .auto_mode(auto_mode),
      .cmd_reject(cmd_reject), .green_led(green_led), .tone_on(tone_on));

   asch_rx_model rx (.clk(clk), .resetn(resetn), .stall(stall), .radio_rate(radio_rate),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .n_rx(n_rx),
      .last_q(last_q));

   // fixed-rate variant
   // A second copy built as the fixed-rate variant sees the same stimulus, so its
   // cadence can be set against the configured limit of the first copy.
   asch_sched #(.MS_CYCLES(1), .FIXED_RATE(1'b1)) dut_fix (.clk(clk), .resetn(resetn),
      .key_press(key_press), .cmd_valid(cmd_valid), .cmd(cmd), .button_short(button_short),
      .button_long(button_long), .meas_valid(meas_valid), .meas_value(meas_value),
      .tx_valid(tx_valid_f), .tx_ready(tx_ready_f), .tx_data(tx_data_f), .sender_addr(),
      .radio_rate(rate_f), .auto_mode(), .cmd_reject(), .green_led(), .tone_on());

   asch_rx_model rx_fix (.clk(clk), .resetn(resetn), .stall(stall), .radio_rate(rate_f),
      .tx_valid(tx_valid_f), .tx_ready(tx_ready_f), .tx_data(tx_data_f), .n_rx(n_rx_f),
      .last_q(last_f));

   // ------------
   // Tasks
   // ------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // queued command delivery
   // The key press opens the window; the command follows one edge later.
   task send_cmd(input bit key, input asch_cmd_t c);
      @(posedge clk);
      key_press <= key;
      @(posedge clk);
      key_press <= 1'b0;
      cmd_valid <= 1'b1;
      cmd <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      rej = cmd_reject;
   endtask

   task pulse(input bit lng);
      @(posedge clk);
      button_short <= !lng;
      button_long <= lng;
      @(posedge clk);
      button_short <= 1'b0;
      button_long <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   task meas(input logic [15:0] v);
      @(posedge clk);
      meas_valid <= 1'b1;
      meas_value <= v;
      @(posedge clk);
      meas_valid <= 1'b0;
   endtask

   task cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task wait_cnt(input int n, input int lim);
      for (int i = 0; i < lim && n_rx < n; i++) @(posedge clk);
      #1;
      check(32'(n_rx), 32'(n));
   endtask

   task print_verdict;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the roughly 70000 cycles of the run.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         n_fail++;
         print_verdict();
      end
   end

   // ------------
   // Main sequence
   // ------------
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      #1;
      check(32'(sender_addr), 32'(ADDR_RST));
      check(32'(radio_rate), 32'(ASCH_RATE_LOW));
      send_cmd(1'b0, '{ASCH_OP_ADDR, 16'h0009});
      check(32'(sender_addr), 32'(ADDR_RST));
      check(32'(rej), 32'h0);
      foreach (bad[i]) begin
         send_cmd(1'b1, bad[i]);
         check(32'(rej), 32'h1);
      end
      check(32'(radio_rate), 32'(ASCH_RATE_LOW));
      send_cmd(1'b1, '{ASCH_OP_ADDR, 16'h0005});
      check(32'(sender_addr), 32'h5);
      check(32'(green_led), 32'h1);
      check(32'(tone_on), 32'h1);
      k = 0;
      p = green_led;
      repeat (700) begin
         @(posedge clk);
         #1;
         if (green_led === 1'b1 && p === 1'b0) k++;
         p = green_led;
      end
      check(32'(k), 32'h2);
      check(32'(green_led), 32'h0);
      check(32'(tone_on), 32'h0);
      send_cmd(1'b1, '{ASCH_OP_BTN, 16'h0001});
      pulse(1'b0);
      check(32'(auto_mode), 32'h0);
      send_cmd(1'b1, '{ASCH_OP_ADDR, 16'h01f4});
      send_cmd(1'b1, '{ASCH_OP_RATE, 16'h0001});
      check(32'(radio_rate), 32'(ASCH_RATE_HIGH));
      send_cmd(1'b1, '{ASCH_OP_ADDR, 16'h0007});
      check(32'(sender_addr), 32'h7);
      check(32'(radio_rate), 32'(ASCH_RATE_HIGH));
      send_cmd(1'b1, '{ASCH_OP_MAXR, 16'h000a});
      pulse(1'b1);
      check(32'(auto_mode), 32'h0);
      pulse(1'b0);
      check(32'(auto_mode), 32'h1);
      base = n_rx;
      base_f = n_rx_f;
      meas(16'h1234);
      wait_cnt(base + 1, 50);
      check(32'(last_q.value), 32'h1234);
      check(32'(last_q.keepalive), 32'h0);
      check(32'(last_q.addr), 32'h7);
      // A burst inside the 200 ms slot must leave as one word.
      meas(16'h1111);
      meas(16'h2222);
      meas(16'h3333);
      cycles(100);
      check(32'(n_rx), 32'(base + 1));
      // The fixed-rate copy has a 100 ms slot and has already sent the latest value.
      check(32'(n_rx_f), 32'(base_f + 2));
      check(32'(last_f.value), 32'h3333);
      wait_cnt(base + 2, 300);
      check(32'(last_q.value), 32'h3333);
      cycles(400);
      check(32'(n_rx), 32'(base + 2));
      // Stall the receiver until the buffer refuses, then drain it.
      @(posedge clk);
      stall <= 1'b1;
      for (k = 0; k < 10; k++) begin
         meas(16'(16'h4000 + k));
         cycles(210);
      end
      check(32'(tx_valid), 32'h1);
      @(posedge clk);
      stall <= 1'b0;
      cycles(2000);
      check(32'(last_q.value), 32'h4009);
      check(32'(tx_valid), 32'h0);
      send_cmd(1'b1, '{ASCH_OP_TMO, 16'h0001});
      send_cmd(1'b1, '{ASCH_OP_KA, 16'h0001});
      base = n_rx;
      meas(16'h5555);
      wait_cnt(base + 1, 300);
      cycles(2100);
      check(32'(last_q.keepalive), 32'h1);
      check(32'(last_q.value), 32'h5555);
      cycles(56000);
      check(32'(auto_mode), 32'h1);
      cycles(3500);
      check(32'(auto_mode), 32'h0);
      print_verdict();
   end
endmodule
